// *** hdl/lsd_pkg.sv ***
// constants, types and decode functions of the segment lcd drive control
package lsd_pkg;

    // ********************************************************
    // register map, byte-wide registers
    // ********************************************************
    localparam int        LSD_AW          = 5;
    localparam int        LSD_DW          = 8;
    localparam logic [4:0] LSD_OFS_CTRL    = 5'h00;
    localparam logic [4:0] LSD_OFS_PRESC   = 5'h01;
    localparam logic [4:0] LSD_OFS_BIASREF = 5'h02;
    localparam logic [4:0] LSD_OFS_LADDER  = 5'h03;
    localparam logic [4:0] LSD_OFS_SEGEN0  = 5'h04;
    localparam logic [4:0] LSD_OFS_STATUS  = 5'h07;
    localparam logic [4:0] LSD_OFS_PIX0    = 5'h10;
    localparam int        LSD_SEGEN_REGS  = 3;
    localparam int        LSD_PIX_REGS    = 12;
    localparam int        LSD_PIX_STRIDE  = 3;

    // ********************************************************
    // field positions and reset values
    // ********************************************************
    localparam int         LSD_CTRL_EN     = 0;
    localparam int         LSD_CTRL_MUX    = 1;
    localparam int         LSD_CTRL_SRC    = 3;
    localparam int         LSD_BIAS_IREF   = 0;
    localparam int         LSD_BIAS_FVR    = 1;
    localparam int         LSD_BIAS_IDLE   = 2;
    localparam int         LSD_BIAS_EXT    = 3;
    localparam int         LSD_LAD_TAP     = 0;
    localparam int         LSD_LAD_LAT     = 4;
    localparam int         LSD_ST_ACTIVE   = 0;
    localparam int         LSD_ST_SHUT     = 1;
    localparam logic [7:0] LSD_RST_REG     = 8'h00;

    // ********************************************************
    // timing counts
    // ********************************************************
    localparam logic [7:0] LSD_FOSC_DIV_MAX = 8'hff;  // divide by 256
    localparam logic [7:0] LSD_PHASE_STEPS  = 8'h20;  // 32 per factor
    localparam logic [3:0] LSD_LADDER_MAX   = 4'hf;   // 16 clocks a period

    typedef enum logic [1:0] {
        LSD_SRC_FOSC,
        LSD_SRC_SOSC,
        LSD_SRC_LFINT
    } lsd_clk_src_t;

    typedef enum logic [1:0] {
        LSD_IDLE,
        LSD_RUN,
        LSD_STOPPING
    } lsd_state_t;

    // commons in use for a common count code
    function automatic logic [3:0] lsd_com_mask(input logic [1:0] mux);
        case (mux)
            2'h0:    lsd_com_mask = 4'h1;
            2'h1:    lsd_com_mask = 4'h3;
            2'h2:    lsd_com_mask = 4'h7;
            default: lsd_com_mask = 4'hf;
        endcase
    endfunction : lsd_com_mask

    // phases per frame: 32 times the mode factor
    function automatic logic [7:0] lsd_frame_phases(input logic [1:0] mux);
        case (mux)
            2'h2:    lsd_frame_phases = 8'(LSD_PHASE_STEPS * 3);
            default: lsd_frame_phases = 8'(LSD_PHASE_STEPS * 4);
        endcase
    endfunction : lsd_frame_phases

endpackage : lsd_pkg

// *** hdl/lsd_drive_ctrl.sv ***
// segment lcd drive control: registers, pin steering, bias gating, frames
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ps
module lsd_drive_ctrl
    import lsd_pkg::*;
#(
    parameter int SEGS = 24                 // segment pins
) (
    input  wire logic              i_ref_clk,      // 20 MHz clock
    input  wire logic              i_reset,        // async, active high
    input  wire logic              i_clk_en,       // low freezes all state
    input  wire logic [LSD_AW-1:0] i_addr,         // register address
    input  wire logic [LSD_DW-1:0] i_wr_data,      // write data
    input  wire logic              i_wr_stb,       // write strobe
    input  wire logic              i_rd_stb,       // read strobe
    output logic      [LSD_DW-1:0] o_rd_data,      // read data, next cycle
    input  wire logic              i_sosc_tick,    // secondary osc tick
    input  wire logic              i_lfint_tick,   // low-freq osc tick
    input  wire logic              i_khz32_tick,   // 32 kHz ladder tick
    input  wire logic [3:0]        i_com_dir,      // common pin directions
    input  wire logic [SEGS-1:0]   i_seg_dir,      // segment pin directions
    output logic [3:0]             o_com_lcd,      // common pin is lcd
    output logic [3:0]             o_com_dir,      // effective com dir
    output logic [SEGS-1:0]        o_seg_lcd,      // segment pin is lcd
    output logic [SEGS-1:0]        o_seg_dir,      // effective seg dir
    output logic [4*SEGS-1:0]      o_pixel_dark,   // pixel bits, com-major
    output logic                   o_active,       // module-active flag
    output logic                   o_ladder_on,    // contrast ladder closed
    output logic [2:0]             o_ladder_tap,   // ladder tap code
    output logic                   o_ladder_mode_a,// ladder in power mode A
    output logic                   o_iref_on,      // internal reference on
    output logic                   o_iref_src_fvr, // 1: 3x fixed ref
    output logic                   o_fvr_request,  // fixed ref wanted
    output logic                   o_fvr_buf_on,   // fixed ref buffer on
    output logic [2:0]             o_ext_bias_en,  // external bias pins
    output logic                   o_frame_start,  // common zero edge
    output logic                   o_shutdown_irq  // shutdown event flag
);

    // ********************************************************
    // register storage
    // ********************************************************
    logic [7:0]   ctrl_q;
    logic [7:0]   presc_q;
    logic [7:0]   bias_q;
    logic [7:0]   ladder_q;
    logic [7:0]   segen_q [LSD_SEGEN_REGS];
    logic [7:0]   pix_q   [LSD_PIX_REGS];
    logic         shut_q;
    lsd_state_t   state_q;
    lsd_state_t   state_d;
    logic         wr;
    logic         rd;
    logic         active;
    logic         iref_en;
    logic         src_fvr;
    logic [1:0]   mux;
    logic [SEGS-1:0] segen_w;

    assign wr      = i_wr_stb & i_clk_en;
    assign rd      = i_rd_stb & i_clk_en;
    assign mux     = ctrl_q[LSD_CTRL_MUX +: 2];
    assign iref_en = bias_q[LSD_BIAS_IREF];
    assign src_fvr = bias_q[LSD_BIAS_FVR];
    assign active  = (state_q != LSD_IDLE);

    // control registers; all zero after reset so pins are plain io
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            ctrl_q   <= LSD_RST_REG;
            presc_q  <= LSD_RST_REG;
            bias_q   <= LSD_RST_REG;
            ladder_q <= LSD_RST_REG;
        end else if (wr) begin
            case (i_addr)
                LSD_OFS_CTRL:    ctrl_q   <= i_wr_data;
                LSD_OFS_PRESC:   presc_q  <= i_wr_data;
                LSD_OFS_BIASREF: bias_q   <= i_wr_data;
                LSD_OFS_LADDER:  ladder_q <= i_wr_data;
                default:         ;
            endcase
        end
    end

    // segment enables and pixel bits, one generate slot per register
    genvar g;
    generate
        for (g = 0; g < LSD_SEGEN_REGS; g++) begin : g_segen
            always_ff @(posedge i_ref_clk or posedge i_reset) begin
                if (i_reset) begin
                    segen_q[g] <= LSD_RST_REG;
                end else if (wr && i_addr == LSD_OFS_SEGEN0 + 5'(g)) begin
                    segen_q[g] <= i_wr_data;
                end
            end
            assign segen_w[8*g +: 8] = segen_q[g];
        end
        // pixel writes land regardless of module state
        for (g = 0; g < LSD_PIX_REGS; g++) begin : g_pix
            always_ff @(posedge i_ref_clk or posedge i_reset) begin
                if (i_reset) begin
                    pix_q[g] <= LSD_RST_REG;
                end else if (wr && i_addr == LSD_OFS_PIX0 + 5'(g)) begin
                    pix_q[g] <= i_wr_data;
                end
            end
        end
        // com c, segment n -> register c*3 + n/8, bit n%8
        for (g = 0; g < 4*SEGS; g++) begin : g_map
            assign o_pixel_dark[g] =
                pix_q[(g / SEGS) * LSD_PIX_STRIDE + (g % SEGS) / 8]
                     [(g % SEGS) % 8];
        end
    endgenerate

    // ********************************************************
    // read port, data valid the cycle after the strobe
    // ********************************************************
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_rd_data <= LSD_RST_REG;
        end else if (rd) begin
            if (i_addr >= LSD_OFS_PIX0 &&
                i_addr < LSD_OFS_PIX0 + 5'(LSD_PIX_REGS)) begin
                o_rd_data <= pix_q[4'(i_addr - LSD_OFS_PIX0)];
            end else if (i_addr >= LSD_OFS_SEGEN0 &&
                i_addr < LSD_OFS_SEGEN0 + 5'(LSD_SEGEN_REGS)) begin
                o_rd_data <= segen_q[2'(i_addr - LSD_OFS_SEGEN0)];
            end else begin
                case (i_addr)
                    LSD_OFS_CTRL:    o_rd_data <= ctrl_q;
                    LSD_OFS_PRESC:   o_rd_data <= presc_q;
                    LSD_OFS_BIASREF: o_rd_data <= bias_q;
                    LSD_OFS_LADDER:  o_rd_data <= ladder_q;
                    LSD_OFS_STATUS:  o_rd_data <= {6'h00, shut_q, active};
                    default:         o_rd_data <= 8'h00; // unmapped
                endcase
            end
        end
    end

    // ********************************************************
    // lcd clock source and frame timing
    // ********************************************************
    logic [7:0] fosc_cnt_q;
    logic [3:0] pre_cnt_q;
    logic [7:0] phase_q;
    logic       lcd_tick;
    logic       phase_tick;
    logic       frame_wrap;
    logic [3:0] pre_max;

    // system clock divided by 256, free running
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            fosc_cnt_q <= 8'h00;
        end else if (i_clk_en) begin
            fosc_cnt_q <= fosc_cnt_q + 8'h01;
        end
    end

    // selected lcd clock tick; spare code falls back to low-freq osc
    always_comb begin
        case (lsd_clk_src_t'(ctrl_q[LSD_CTRL_SRC +: 2]))
            LSD_SRC_FOSC: lcd_tick = (fosc_cnt_q == LSD_FOSC_DIV_MAX);
            LSD_SRC_SOSC: lcd_tick = i_sosc_tick;
            default:      lcd_tick = i_lfint_tick;
        endcase
    end

    // prescale code zero is read as one so the divider never stalls
    assign pre_max    = (presc_q[3:0] == 4'h0) ? 4'h0 : presc_q[3:0] - 4'h1;
    assign phase_tick = lcd_tick && (pre_cnt_q == pre_max);
    assign frame_wrap = phase_tick &&
                        (phase_q == lsd_frame_phases(mux) - 8'h01);

    // prescale and phase counters run only while the module is active
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            pre_cnt_q <= 4'h0;
            phase_q   <= 8'h00;
        end else if (i_clk_en) begin
            if (!active) begin
                pre_cnt_q <= 4'h0;
                phase_q   <= 8'h00;
            end else if (lcd_tick) begin
                pre_cnt_q <= phase_tick ? 4'h0 : pre_cnt_q + 4'h1;
                if (phase_tick) begin
                    phase_q <= frame_wrap ? 8'h00 : phase_q + 8'h01;
                end
            end
        end
    end

    // frame start pulse: common zero leading edge
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_frame_start <= 1'b0;
        end else if (i_clk_en) begin
            o_frame_start <= active && frame_wrap;
        end
    end

    // ********************************************************
    // module activity and shutdown event
    // ********************************************************
    // shutdown waits for a frame edge so no pixel is left with dc on it
    always_comb begin
        state_d = state_q;
        case (state_q)
            LSD_IDLE: begin
                if (ctrl_q[LSD_CTRL_EN]) state_d = LSD_RUN;
            end
            LSD_RUN: begin
                if (!ctrl_q[LSD_CTRL_EN]) state_d = LSD_STOPPING;
            end
            LSD_STOPPING: begin
                if (ctrl_q[LSD_CTRL_EN]) state_d = LSD_RUN;
                else if (frame_wrap)     state_d = LSD_IDLE;
            end
            default: state_d = LSD_IDLE;
        endcase
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            state_q <= LSD_IDLE;
        end else if (i_clk_en) begin
            state_q <= state_d;
        end
    end

    // sticky shutdown flag, write one to clear; a new event beats the clear
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            shut_q <= 1'b0;
        end else if (i_clk_en) begin
            if (active && state_d == LSD_IDLE) begin
                shut_q <= 1'b1;
            end else if (wr && i_addr == LSD_OFS_STATUS &&
                         i_wr_data[LSD_ST_SHUT]) begin
                shut_q <= 1'b0;
            end
        end
    end

    // ********************************************************
    // ladder power mode timing on the 32 kHz tick
    // ********************************************************
    logic [3:0] lad_cnt_q;
    logic [2:0] lat;
    assign lat = ladder_q[LSD_LAD_LAT +: 3];

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            lad_cnt_q <= 4'h0;
        end else if (i_clk_en) begin
            if (!active) begin
                lad_cnt_q <= 4'h0;
            end else if (i_khz32_tick) begin
                lad_cnt_q <= (lad_cnt_q == LSD_LADDER_MAX) ? 4'h0
                                                          : lad_cnt_q + 4'h1;
            end
        end
    end

    // ********************************************************
    // registered analog controls and pin steering
    // ********************************************************
    logic mode_a;
    logic iref_on;
    assign mode_a  = active && (lat != 3'h0) &&
                     (lad_cnt_q < {1'b0, lat});
    assign iref_on = active && iref_en;

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_active        <= 1'b0;
            o_ladder_on     <= 1'b0;
            o_ladder_tap    <= 3'h0;
            o_ladder_mode_a <= 1'b0;
            o_iref_on       <= 1'b0;
            o_iref_src_fvr  <= 1'b0;
            o_fvr_request   <= 1'b0;
            o_fvr_buf_on    <= 1'b0;
            o_ext_bias_en   <= 3'h0;
            o_shutdown_irq  <= 1'b0;
        end else if (i_clk_en) begin
            o_active        <= active;
            // no internal source means contrast circuit off too
            o_ladder_on     <= iref_on;
            o_ladder_tap    <= ladder_q[LSD_LAD_TAP +: 3];
            o_ladder_mode_a <= mode_a;
            o_iref_on       <= iref_on;
            o_iref_src_fvr  <= src_fvr;
            o_fvr_request   <= iref_on && src_fvr;
            o_fvr_buf_on    <= iref_on && src_fvr &&
                               !(bias_q[LSD_BIAS_IDLE] && !mode_a);
            // independent of the ladder, both may run together
            o_ext_bias_en   <= bias_q[LSD_BIAS_EXT +: 3];
            o_shutdown_irq  <= shut_q;
        end
    end

    // lcd pins drive out (dir 0); others follow their direction bit
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_com_lcd <= 4'h0;
            o_com_dir <= 4'hf;
            o_seg_lcd <= '0;
            o_seg_dir <= '1;
        end else if (i_clk_en) begin
            o_com_lcd <= ctrl_q[LSD_CTRL_EN] ? lsd_com_mask(mux) : 4'h0;
            o_com_dir <= i_com_dir &
                         ~(ctrl_q[LSD_CTRL_EN] ? lsd_com_mask(mux)
                                               : 4'h0);
            o_seg_lcd <= segen_w;
            o_seg_dir <= i_seg_dir & ~segen_w;
        end
    end

    // ********************************************************
    // assertions
    // ********************************************************
    sequence s_stop_edge;
        i_clk_en && active && state_d == LSD_IDLE;
    endsequence
    sequence s_wr_pix0;
        wr && i_addr == LSD_OFS_PIX0;
    endsequence
    sequence s_rd_pix0;
        rd && i_addr == LSD_OFS_PIX0;
    endsequence

    property p_tap;
        @(posedge i_ref_clk) disable iff (i_reset)
        i_clk_en |=> o_ladder_tap == $past(ladder_q[2:0]);
    endproperty
    a_tap: assert property (p_tap) else $error("tap mismatch");
    property p_ladder_off;
        @(posedge i_ref_clk) disable iff (i_reset)
        i_clk_en && !active |=> !o_ladder_on && !o_active;
    endproperty
    a_ladder_off: assert property (p_ladder_off)
        else $error("ladder on while inactive");
    property p_no_iref;
        @(posedge i_ref_clk) disable iff (i_reset)
        i_clk_en && !iref_en |=> !o_ladder_on && !o_iref_on;
    endproperty
    a_no_iref: assert property (p_no_iref)
        else $error("contrast on without internal source");
    property p_iref_off;
        @(posedge i_ref_clk) disable iff (i_reset)
        o_iref_on |-> o_active;
    endproperty
    a_iref_off: assert property (p_iref_off)
        else $error("reference on while inactive");
    property p_buf_idle;
        @(posedge i_ref_clk) disable iff (i_reset)
        i_clk_en && bias_q[LSD_BIAS_IDLE] && !mode_a |=> !o_fvr_buf_on;
    endproperty
    a_buf_idle: assert property (p_buf_idle)
        else $error("buffer on in mode B with idle set");
    property p_fvr_req;
        @(posedge i_ref_clk) disable iff (i_reset)
        o_iref_on && o_iref_src_fvr |-> o_fvr_request;
    endproperty
    a_fvr_req: assert property (p_fvr_req)
        else $error("fixed reference not requested");
    property p_com_mask;
        @(posedge i_ref_clk) disable iff (i_reset)
        i_clk_en && ctrl_q[LSD_CTRL_EN] && mux == 2'h2
        |=> o_com_lcd == 4'h7 && o_com_dir[3] == $past(i_com_dir[3]);
    endproperty
    a_com_mask: assert property (p_com_mask)
        else $error("common mask wrong");
    property p_seg_dir;
        @(posedge i_ref_clk) disable iff (i_reset)
        i_clk_en |=> o_seg_dir == ($past(i_seg_dir) & ~o_seg_lcd);
    endproperty
    a_seg_dir: assert property (p_seg_dir)
        else $error("segment enable did not override direction");
    property p_shutdown;
        @(posedge i_ref_clk) disable iff (i_reset)
        s_stop_edge |=> shut_q ##1 (o_shutdown_irq || !i_clk_en);
    endproperty
    a_shutdown: assert property (p_shutdown)
        else $error("shutdown event missed");
    property p_pix_rb;
        @(posedge i_ref_clk) disable iff (i_reset)
        s_wr_pix0 ##1 s_rd_pix0 |=> o_rd_data == $past(i_wr_data, 2);
    endproperty
    a_pix_rb: assert property (p_pix_rb)
        else $error("pixel readback wrong");

endmodule : lsd_drive_ctrl

// *** test/lsd_glass_model.sv ***
// lcd glass stand-in: counts frames and shows the corner pixel
`timescale 1ns/1ps
module lsd_glass_model (
    input  wire logic        i_ref_clk,     // bench clock
    input  wire logic        i_reset,       // async, high
    input  wire logic        i_frame_start, // frame mark
    input  wire logic [95:0] i_pixel_dark,  // pixel bits
    output logic      [15:0] o_frames,      // frames seen
    output logic             o_corner       // common_line_zero seg0 dark
);
    // the glass has no way to refuse a frame, so it only counts them
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_frames <= 16'h0000;
        end else if (i_frame_start) begin
            o_frames <= o_frames + 16'h0001;
        end
    end
    assign o_corner = i_pixel_dark[0];
endmodule : lsd_glass_model

// *** test/lsd_drive_ctrl_tb.sv ***
// self-checking bench of the segment lcd drive control
`timescale 1ns/1ps
module lsd_drive_ctrl_tb;
    import lsd_pkg::*;
    logic i_ref_clk = 0, i_reset = 1, i_clk_en = 1;
    logic i_wr_stb = 0, i_rd_stb = 0, i_sosc_tick = 0;
    logic i_lfint_tick = 0, i_khz32_tick = 0;
    logic [4:0] i_addr = 5'h00;
    logic [7:0] i_wr_data = 8'h00, o_rd_data, d;
    logic [3:0] i_com_dir = 4'ha, o_com_lcd, o_com_dir;
    logic [23:0] i_seg_dir = 24'h3c3c3c, o_seg_lcd, o_seg_dir;
    logic [95:0] o_pixel_dark, pe;
    logic o_active, o_ladder_on, o_ladder_mode_a, o_iref_on;
    logic o_iref_src_fvr, o_fvr_request, o_fvr_buf_on;
    logic o_frame_start, o_shutdown_irq, corner;
    logic [2:0] o_ladder_tap, o_ext_bias_en;
    logic [15:0] frames, f0;
    logic [3:0] mk;
    int fails = 0, n_tests = 0, n;

    lsd_drive_ctrl DUT (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
        .i_clk_en(i_clk_en), .i_addr(i_addr), .i_wr_data(i_wr_data),
        .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data),
        .i_sosc_tick(i_sosc_tick), .i_lfint_tick(i_lfint_tick),
        .i_khz32_tick(i_khz32_tick), .i_com_dir(i_com_dir),
        .i_seg_dir(i_seg_dir), .o_com_lcd(o_com_lcd),
        .o_com_dir(o_com_dir), .o_seg_lcd(o_seg_lcd),
        .o_seg_dir(o_seg_dir), .o_pixel_dark(o_pixel_dark),
        .o_active(o_active), .o_ladder_on(o_ladder_on),
        .o_ladder_tap(o_ladder_tap), .o_ladder_mode_a(o_ladder_mode_a),
        .o_iref_on(o_iref_on), .o_iref_src_fvr(o_iref_src_fvr),
        .o_fvr_request(o_fvr_request), .o_fvr_buf_on(o_fvr_buf_on),
        .o_ext_bias_en(o_ext_bias_en), .o_frame_start(o_frame_start),
        .o_shutdown_irq(o_shutdown_irq));
    lsd_glass_model glass (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
        .i_frame_start(o_frame_start), .i_pixel_dark(o_pixel_dark),
        .o_frames(frames), .o_corner(corner));

    // 20 MHz clock
    always #25 i_ref_clk = ~i_ref_clk;

    // ****************************************
    // bus and check helpers
    // ****************************************
    task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_wr_data <= v;
        i_wr_stb <= 1'b1;
        @(posedge i_ref_clk);
        i_wr_stb <= 1'b0;
        @(posedge i_ref_clk);
        #1;
    endtask : wr

    // read data appears in the cycle after the strobe and holds until the next read
    task automatic rd(input logic [4:0] a, output logic [7:0] v);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_rd_stb <= 1'b1;
        @(posedge i_ref_clk);
        i_rd_stb <= 1'b0;
        #1 v = o_rd_data;
    endtask : rd

    // write, then read back in the very next cycle with no gap
    task automatic wr_rd(input logic [4:0] a, input logic [7:0] v,
                         output logic [7:0] r);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_wr_data <= v;
        i_wr_stb <= 1'b1;
        @(posedge i_ref_clk);
        i_wr_stb <= 1'b0;
        i_rd_stb <= 1'b1;
        @(posedge i_ref_clk);
        i_rd_stb <= 1'b0;
        #1 r = o_rd_data;
    endtask : wr_rd

    // bounded wait for a level of the active flag or a frame pulse
    task automatic wait_act(input logic v);
        n = 0;
        while (o_active !== v && n < 800) begin
            @(posedge i_ref_clk);
            #1 n++;
        end
        chk(96'(o_active), 96'(v));
    endtask : wait_act

    task automatic wait_frame(input int lim, output int c);
        c = 0;
        do begin
            @(posedge i_ref_clk);
            #1 c++;
        end while (o_frame_start !== 1'b1 && c < lim);
    endtask : wait_frame

    function automatic logic [7:0] pv(input int i);
        return 8'(i * 37 + 5);
    endfunction : pv

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_pixels;
        chk({o_com_dir, o_seg_lcd, o_seg_dir}, 52'hf000000ffffff);
        chk(96'(o_com_lcd), 96'h0);
        wr_rd(LSD_OFS_PIX0, 8'h5a, d);
        chk(96'(d), 96'h5a);
        for (int i = 0; i < 12; i++) begin
            wr(LSD_OFS_PIX0 + 5'(i), pv(i));
            pe[(i / 3) * 24 + (i % 3) * 8 +: 8] = pv(i);
        end
        for (int i = 0; i < 12; i++) begin
            rd(LSD_OFS_PIX0 + 5'(i), d);
            chk(96'(d), 96'(pv(i)));
        end
        chk(o_pixel_dark, pe);
        chk(96'(corner), 96'(pe[0]));
        rd(5'h1f, d);
        chk(96'(d), 96'h0);
    endtask : t_pixels

    task automatic t_segs;
        wr(LSD_OFS_SEGEN0, 8'ha5);
        wr(LSD_OFS_SEGEN0 + 5'h1, 8'h0f);
        wr(LSD_OFS_SEGEN0 + 5'h2, 8'hf0);
        chk(96'(o_seg_lcd), 96'(24'hf00fa5));
        chk(96'(o_seg_dir), 96'(i_seg_dir & ~24'hf00fa5));
        // a write while the clock enable is low must not land
        @(posedge i_ref_clk);
        i_clk_en <= 1'b0;
        wr(LSD_OFS_SEGEN0, 8'hff);
        i_clk_en <= 1'b1;
        rd(LSD_OFS_SEGEN0, d);
        chk(96'(d), 96'ha5);
    endtask : t_segs

    // bias gating before and after the module comes up
    task automatic t_bias;
        wr(LSD_OFS_BIASREF, 8'h2b);
        wr(LSD_OFS_LADDER, 8'h07);
        chk(96'({o_ladder_on, o_iref_on}), 96'h0);
        chk(96'(o_ext_bias_en), 96'(3'h5));
        chk(96'(o_ladder_tap), 96'(3'h7));
        wr(LSD_OFS_CTRL, 8'h09);
        wait_act(1'b1);
        chk(96'({o_ladder_on, o_iref_on, o_iref_src_fvr}), 96'h7);
        chk(96'(o_ext_bias_en), 96'h5);
        chk(96'({o_fvr_request, o_fvr_buf_on}), 96'h3);
        wr(LSD_OFS_BIASREF, 8'h2f);
        chk(96'({o_ladder_mode_a, o_fvr_buf_on}), 96'h0);
        // mode A for three ticks of the 32 kHz clock, then mode B
        wr(LSD_OFS_LADDER, 8'h37);
        chk(96'({o_ladder_mode_a, o_fvr_buf_on}), 96'h3);
        @(posedge i_ref_clk);
        i_khz32_tick <= 1'b1;
        repeat (3) @(posedge i_ref_clk);
        i_khz32_tick <= 1'b0;
        @(posedge i_ref_clk);
        #1 chk(96'({o_ladder_mode_a, o_fvr_buf_on}), 96'h0);
        wr(LSD_OFS_BIASREF, 8'h28);
        chk(96'({o_ladder_on, o_iref_on, o_iref_src_fvr}), 96'h0);
    endtask : t_bias

    // every common count, with its frame length on a tick every cycle
    task automatic t_mux;
        wr(LSD_OFS_PRESC, 8'h02);
        i_sosc_tick <= 1'b1;
        // pass four repeats four commons on the low-freq osc alone
        for (int m = 0; m < 5; m++) begin
            if (m == 4) begin
                i_sosc_tick <= 1'b0;
                i_lfint_tick <= 1'b1;
            end
            wr(LSD_OFS_CTRL, (m == 4) ? 8'h17 : 8'(8'h09 | (m << 1)));
            mk = (m == 4) ? 4'hf : 4'((5'h2 << m) - 5'h1);
            chk(96'(o_com_lcd), 96'(mk));
            chk(96'(o_com_dir), 96'(i_com_dir & ~mk));
            wait_frame(2000, n);
            f0 = frames;
            wait_frame(2000, n);
            chk(96'(n), 96'(2 * 32 * ((m == 2) ? 3 : 4)));
            chk(96'(frames), 96'(f0 + 16'h0001));
        end
    endtask : t_mux

    // disable waits for the frame end, then the shutdown flag rises
    task automatic t_shut;
        wr(LSD_OFS_CTRL, 8'h10);
        wait_act(1'b0);
        @(posedge i_ref_clk);
        #1 chk(96'(o_shutdown_irq), 96'h1);
        chk(96'(o_ladder_on), 96'h0);
        rd(LSD_OFS_STATUS, d);
        chk(96'(d), 96'h02);
        wr(LSD_OFS_STATUS, 8'h03);
        rd(LSD_OFS_STATUS, d);
        chk(96'(d), 96'h00);
    endtask : t_shut

    // system clock / 256 source: a frame is 96 ticks of 256 cycles
    task automatic t_fosc;
        wr(LSD_OFS_PRESC, 8'h01);
        wr(LSD_OFS_CTRL, 8'h05);
        wait_frame(30000, n);
        wait_frame(30000, n);
        chk(96'(n), 96'(256 * 32 * 3));
    endtask : t_fosc

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    // main sequence after ten cycles of reset
    initial begin
        repeat (10) @(posedge i_ref_clk);
        i_reset <= 1'b0;
        #1;
        t_pixels();
        t_segs();
        t_bias();
        t_mux();
        t_shut();
        t_fosc();
        complete_run();
    end

    // watchdog well beyond the roughly 52000 cycles the run needs
    initial begin
        #(50 * 90000);
        fails++;
        complete_run();
    end
endmodule : lsd_drive_ctrl_tb
